// ==== hdl/prt_pkg.sv ====
package prt_pkg;

  // serial word layout
  localparam int          WORD_W         = 29;
  localparam int          FIELD_W        = 12;
  localparam int          NUM_WORDS      = 5;
  localparam logic [2:0]  ADDR_FREQ      = 3'h0;
  localparam logic [2:0]  ADDR_PHASE     = 3'h1;
  localparam logic [2:0]  ADDR_MODULUS   = 3'h2;
  localparam logic [2:0]  ADDR_FUNCTION  = 3'h3;
  localparam logic [2:0]  ADDR_MODE      = 3'h4;
  localparam int          MODE_LSB       = 19;
  localparam int          COUNT_LSB      = 7;
  localparam int          MODULUS_LSB    = 3;
  localparam int          PHASE_LSB      = 3;
  localparam int          SD_RESET_BIT   = 14;
  localparam int          DITHER_BIT     = 13;
  localparam logic [1:0]  MODE_FASTLOCK  = 2'h1;
  localparam logic [1:0]  MODE_RESYNC    = 2'h2;
  localparam logic [11:0] MODULUS_MIN    = 12'h002;
  // smallest modulus accepted while dither is on
  localparam logic [11:0] DITHER_FLOOR   = 12'h032;
  localparam int          SCLK_MAX_MHZ   = 20;

  // bus register map, byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_MODE_WORD  = 8'h08;
  localparam logic [7:0]  OFS_MODULUS_WORD = 8'h0C;
  localparam logic [7:0]  OFS_PHASE_WORD = 8'h10;
  localparam logic [7:0]  OFS_FREQ_WORD  = 8'h14;
  localparam logic [7:0]  OFS_FUNC_WORD  = 8'h18;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0001;
  localparam int          CTRL_SER_EN    = 0;
  localparam int          ST_REALIGNED   = 0;
  localparam int          ST_MODULUS_ERR = 1;
  localparam int          ST_WIDEBAND    = 2;
  localparam int          ST_ALIGN_LSB   = 4;
  localparam logic        HRESP_OKAY     = 1'b0;

  typedef enum logic [1:0] {
    AL_IDLE  = 2'h0,
    AL_WAIT1 = 2'h1,
    AL_WAIT2 = 2'h3
  } prt_align_e;

  typedef struct packed {
    logic [1:0]  mode;
    logic [11:0] count;
    logic [11:0] modulus;
    logic [11:0] phase;
    logic        sd_reset;
    logic        dither;
  } prt_timer_cfg_s;

endpackage

// ==== hdl/prt_resync_timer.sv ====
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
// What this block does
// (RULE1) resync timer runs only when the mode field holds binary 10
// (RULE2) sync pulses repeat every interval count times modulus reference cycles
// (RULE3) interval count is the twelve-bit field, host writes 1 to 4095
// (RULE4) period uses the twelve-bit modulus field of the modulus word
// (RULE5) phase realigns on the second sync pulse after a frequency strobe
// (RULE6) host should pick an interval at least the worst-case lock time
// (RULE7) output phase offset follows the phase word, steps of 360/modulus
// (RULE8) one data bit enters the 29-bit shift register per serial clock rise
// (RULE9) load strobe high moves the shift register into the addressed latch
// (RULE10) host keeps the serial clock at or below 20 MHz
// (RULE11) mode binary 01 selects fast lock, count sets wideband length
// (RULE12) modulus valid from 2 to 4095, at least 50 with dither
// (RULE13) reset bit clear restarts modulator from phase word on frequency writes
// (RULE14) words shift MSB first, low three bits pick the latch
// (RULE15) every load strobe rise restarts the timer count
module prt_resync_timer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sclk_pin,
  input  wire logic        sdata_pin,
  input  wire logic        load_strobe_pin,
  output logic             sync_pulse,
  output logic             realign_pulse,
  output logic      [11:0] phase_offset,
  output logic             wideband,
  output logic             modulator_restart
);

  logic [2:0]                       sclk_sync;
  logic [1:0]                       sdata_sync;
  logic [2:0]                       strobe_sync;
  logic                             serial_en;
  logic                             sclk_take;
  logic                             strobe_take;
  logic [prt_pkg::WORD_W-1:0]       shift_reg;
  logic [prt_pkg::WORD_W-1:0]       word_mem [0:prt_pkg::NUM_WORDS-1];
  logic [2:0]                       word_addr;
  logic                             freq_strobe;
  prt_pkg::prt_timer_cfg_s          cfg;
  logic                             modulus_err;
  logic                             resync_en;
  logic [11:0]                      sub_cnt_reg;
  logic [11:0]                      int_cnt_reg;
  logic                             sub_last;
  logic                             int_last;
  logic                             tick;
  prt_pkg::prt_align_e              align_reg;
  logic [11:0]                      wb_cnt_reg;
  logic                             realign_flag_reg;
  logic [31:0]                      ctrl_reg;
  logic                             wr_pend_reg;
  logic [7:0]                       wr_ofs_reg;
  logic                             addr_phase;
  logic [31:0]                      rd_next;
  logic [31:0]                      status_word;

  // synchronisers: stage 0 feeds only stage 1; stage 2 exists for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_sync   <= 3'h0;
      sdata_sync  <= 2'h0;
      strobe_sync <= 3'h0;
    end else if (ce) begin
      sclk_sync   <= {sclk_sync[1:0], sclk_pin};
      sdata_sync  <= {sdata_sync[0], sdata_pin};
      strobe_sync <= {strobe_sync[1:0], load_strobe_pin};
    end
  end

  assign serial_en   = ctrl_reg[prt_pkg::CTRL_SER_EN];
  assign sclk_take   = serial_en & sclk_sync[1] & ~sclk_sync[2];
  assign strobe_take = serial_en & strobe_sync[1] & ~strobe_sync[2];
  assign word_addr   = shift_reg[2:0];
  assign freq_strobe = strobe_take & (word_addr == prt_pkg::ADDR_FREQ);

  // (RULE8) shift in on clock rise
  // (RULE14) msb first shift
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg <= 29'h0000000;
    end else if (ce && sclk_take) begin
      shift_reg <= {shift_reg[prt_pkg::WORD_W-2:0], sdata_sync[1]};
    end
  end

  // (RULE9) latch transfer on strobe
  // (RULE14) address decode on low bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < prt_pkg::NUM_WORDS; i++) begin
        word_mem[i] <= 29'h0000000;
      end
    end else if (ce && strobe_take && (int'(word_addr) < prt_pkg::NUM_WORDS)) begin
      word_mem[word_addr] <= shift_reg;
    end
  end

  // (RULE4) modulus field extraction
  always_comb begin
    cfg.mode     = word_mem[prt_pkg::ADDR_MODE][prt_pkg::MODE_LSB +: 2];
    cfg.count    = word_mem[prt_pkg::ADDR_MODE][prt_pkg::COUNT_LSB +: prt_pkg::FIELD_W];
    cfg.modulus  = word_mem[prt_pkg::ADDR_MODULUS][prt_pkg::MODULUS_LSB +: prt_pkg::FIELD_W];
    cfg.phase    = word_mem[prt_pkg::ADDR_PHASE][prt_pkg::PHASE_LSB +: prt_pkg::FIELD_W];
    cfg.sd_reset = word_mem[prt_pkg::ADDR_FUNCTION][prt_pkg::SD_RESET_BIT];
    cfg.dither   = word_mem[prt_pkg::ADDR_FUNCTION][prt_pkg::DITHER_BIT];
  end

  // (RULE12) modulus range check
  assign modulus_err = (cfg.modulus < prt_pkg::MODULUS_MIN) ||
                       (cfg.dither && (cfg.modulus < prt_pkg::DITHER_FLOOR));
  // (RULE1) mode 10 enables; (RULE3) zero count keeps it idle
  assign resync_en = (cfg.mode == prt_pkg::MODE_RESYNC) && (cfg.count != 12'h000) && !modulus_err;

  assign sub_last = (sub_cnt_reg == cfg.modulus - 12'h001);
  assign int_last = (int_cnt_reg == cfg.count - 12'h001);
  assign tick     = resync_en & sub_last & int_last;

  // (RULE2) period counters
  // (RULE15) strobe restarts count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sub_cnt_reg <= 12'h000;
      int_cnt_reg <= 12'h000;
    end else if (ce) begin
      if (strobe_take || !resync_en) begin
        sub_cnt_reg <= 12'h000;
        int_cnt_reg <= 12'h000;
      end else if (sub_last) begin
        sub_cnt_reg <= 12'h000;
        int_cnt_reg <= int_last ? 12'h000 : int_cnt_reg + 12'h001;
      end else begin
        sub_cnt_reg <= sub_cnt_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_pulse <= 1'b0;
    end else if (ce) begin
      sync_pulse <= tick & ~strobe_take;
    end
  end

  // (RULE5) second pulse tracking; a later strobe of any word restarts the count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      align_reg <= prt_pkg::AL_IDLE;
    end else if (ce) begin
      if (strobe_take) begin
        if (freq_strobe || (align_reg != prt_pkg::AL_IDLE)) begin
          align_reg <= prt_pkg::AL_WAIT1;
        end
      end else begin
        case (align_reg)
          prt_pkg::AL_WAIT1: begin
            if (tick) align_reg <= prt_pkg::AL_WAIT2;
          end
          prt_pkg::AL_WAIT2: begin
            if (tick) align_reg <= prt_pkg::AL_IDLE;
          end
          default: align_reg <= prt_pkg::AL_IDLE;
        endcase
      end
    end
  end

  // (RULE5) realign on second pulse
  // (RULE7) phase offset from phase word
  // (RULE13) modulator restart on frequency write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      realign_pulse     <= 1'b0;
      modulator_restart <= 1'b0;
      phase_offset      <= 12'h000;
    end else if (ce) begin
      realign_pulse     <= tick && !strobe_take && (align_reg == prt_pkg::AL_WAIT2);
      modulator_restart <= freq_strobe && !cfg.sd_reset;
      if ((tick && !strobe_take && (align_reg == prt_pkg::AL_WAIT2)) ||
          (freq_strobe && !cfg.sd_reset)) begin
        phase_offset <= cfg.phase;
      end
    end
  end

  // (RULE11) fast-lock wideband window, count cycles long
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wb_cnt_reg <= 12'h000;
      wideband   <= 1'b0;
    end else if (ce) begin
      if (freq_strobe && (cfg.mode == prt_pkg::MODE_FASTLOCK)) begin
        wb_cnt_reg <= cfg.count;
        wideband   <= (cfg.count != 12'h000);
      end else if (wb_cnt_reg != 12'h000) begin
        wb_cnt_reg <= wb_cnt_reg - 12'h001;
        wideband   <= (wb_cnt_reg != 12'h001);
      end else begin
        wideband   <= 1'b0;
      end
    end
  end

  // bus slave: zero wait states, read data registered into the data phase
  assign addr_phase  = hsel & htrans[1] & hready;
  assign status_word = {26'h0000000, align_reg, 1'b0, wideband, modulus_err, realign_flag_reg};

  // only haddr[7:0] is decoded, so the map aliases across the slave's window
  always_comb begin
    rd_next = 32'h0000_0000;
    if (haddr[7:0] == prt_pkg::OFS_CTRL) begin
      rd_next = ctrl_reg;
    end else if (haddr[7:0] == prt_pkg::OFS_STATUS) begin
      rd_next = status_word;
    end else if (haddr[7:0] == prt_pkg::OFS_MODE_WORD) begin
      rd_next = {3'h0, word_mem[prt_pkg::ADDR_MODE]};
    end else if (haddr[7:0] == prt_pkg::OFS_MODULUS_WORD) begin
      rd_next = {3'h0, word_mem[prt_pkg::ADDR_MODULUS]};
    end else if (haddr[7:0] == prt_pkg::OFS_PHASE_WORD) begin
      rd_next = {3'h0, word_mem[prt_pkg::ADDR_PHASE]};
    end else if (haddr[7:0] == prt_pkg::OFS_FREQ_WORD) begin
      rd_next = {3'h0, word_mem[prt_pkg::ADDR_FREQ]};
    end else if (haddr[7:0] == prt_pkg::OFS_FUNC_WORD) begin
      rd_next = {3'h0, word_mem[prt_pkg::ADDR_FUNCTION]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg  <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= prt_pkg::HRESP_OKAY;
    end else if (ce) begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_ofs_reg  <= haddr[7:0];
      hrdata      <= (addr_phase && !hwrite) ? rd_next : 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= prt_pkg::HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= prt_pkg::CTRL_RST;
    end else if (ce && wr_pend_reg && (wr_ofs_reg == prt_pkg::OFS_CTRL)) begin
      ctrl_reg <= {31'h00000000, hwdata[prt_pkg::CTRL_SER_EN]};
    end
  end

  // sticky realign flag: a new event wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      realign_flag_reg <= 1'b0;
    end else if (ce) begin
      realign_flag_reg <= realign_pulse |
        (realign_flag_reg & ~(wr_pend_reg && (wr_ofs_reg == prt_pkg::OFS_STATUS) &&
                              hwdata[prt_pkg::ST_REALIGNED]));
    end
  end

  // checking helpers: cycles since the last sync pulse
  logic [23:0] gap_cnt;
  logic        gap_ok;
  logic [23:0] period_m1;
  assign period_m1 = ({12'h000, cfg.count} * {12'h000, cfg.modulus}) - 24'h000001;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_cnt <= 24'h000000;
      gap_ok  <= 1'b0;
    end else if (ce) begin
      gap_cnt <= sync_pulse ? 24'h000000 : gap_cnt + 24'h000001;
      gap_ok  <= (sync_pulse | gap_ok) & ~strobe_take & resync_en;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  AST_MODE_GATE: assert property ( // RULE1
    sync_pulse |-> $past(cfg.mode) == prt_pkg::MODE_RESYNC)
    else $error("sync pulse outside resync mode");
  AST_PERIOD: assert property ( // RULE2
    (sync_pulse && gap_ok) |-> gap_cnt == period_m1)
    else $error("sync period differs from count times modulus");
  AST_ZERO_COUNT: assert property ( // RULE3
    ($past(cfg.count) == 12'h000) |-> !sync_pulse)
    else $error("sync pulse with zero interval count");
  AST_SUB_RANGE: assert property ( // RULE4
    resync_en |-> sub_cnt_reg < cfg.modulus)
    else $error("modulus counter out of range");
  AST_SECOND_PULSE: assert property ( // RULE5
    realign_pulse |-> sync_pulse && $past(align_reg) == prt_pkg::AL_WAIT2)
    else $error("realign not on second sync pulse");
  AST_PHASE_OUT: assert property ( // RULE7
    realign_pulse |-> phase_offset == $past(cfg.phase))
    else $error("phase offset not taken from phase word");
  AST_SHIFT: assert property ( // RULE8
    sclk_take |=> shift_reg == {$past(shift_reg[27:0]), $past(sdata_sync[1])})
    else $error("serial bit not shifted in");
  AST_LATCH: assert property ( // RULE9
    (strobe_take && word_addr < 3'h5) |=> word_mem[$past(word_addr)] == $past(shift_reg))
    else $error("latch not loaded on strobe");
  AST_FASTLOCK: assert property ( // RULE11
    $rose(wideband) |-> $past(cfg.mode, 2) == prt_pkg::MODE_FASTLOCK)
    else $error("wideband outside fast-lock mode");
  AST_MODULUS_ERR: assert property ( // RULE12
    (cfg.dither && cfg.modulus == 12'h031) |-> modulus_err && !resync_en)
    else $error("dithered modulus below minimum accepted");
  AST_RESTART: assert property ( // RULE13
    modulator_restart |-> $past(freq_strobe) && !$past(cfg.sd_reset))
    else $error("modulator restart without frequency write");
  AST_TIMER_RESTART: assert property ( // RULE15
    strobe_take |=> sub_cnt_reg == 12'h000 && int_cnt_reg == 12'h000 && !sync_pulse)
    else $error("timer not restarted by strobe");

endmodule

// ==== tb/prt_serial_host.sv ====
`timescale 1ns/1ns
module prt_serial_host (
  input  wire logic hclk,
  output logic      sclk_pin,
  output logic      sdata_pin,
  output logic      load_strobe_pin
);
  // serial clock rests low between frames
  initial begin
    sclk_pin = 1'b0;
    sdata_pin = 1'b0;
    load_strobe_pin = 1'b0;
  end

  task automatic send_word(input logic [prt_pkg::WORD_W-1:0] w);
    for (int i = prt_pkg::WORD_W - 1; i >= 0; i--) begin
      sdata_pin <= w[i];
      repeat (4) @(posedge hclk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      sclk_pin <= 1'b0;
    end
    // data no longer held: show the opposite level so a late sample is wrong
    sdata_pin <= ~w[0];
    repeat (4) @(posedge hclk);
    load_strobe_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    load_strobe_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
endmodule

// ==== tb/tb_prt_resync_timer.sv ====
`timescale 1ns/1ns
module tb_prt_resync_timer;
  localparam logic [11:0] PH   = 12'h5A3;
  localparam logic [11:0] PH2  = 12'h2C7;
  localparam logic [28:0] FREQ = {26'h0ABCDE, prt_pkg::ADDR_FREQ};
  logic        hclk;
  logic        hresetn = 1'b0;
  logic        ce = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sclk_pin;
  logic        sdata_pin;
  logic        load_strobe_pin;
  logic        sync_pulse;
  logic        realign_pulse;
  logic [11:0] phase_offset;
  logic        wideband;
  logic        modulator_restart;
  logic [31:0] rd;
  logic [31:0] syncs = 32'h0;
  logic [31:0] realigns = 32'h0;
  logic [31:0] restarts = 32'h0;
  logic [31:0] wb_cycles = 32'h0;
  int          failures = 0;
  int          compares = 0;

  prt_resync_timer prt_resync_timer_i (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sclk_pin, .sdata_pin,
    .load_strobe_pin, .sync_pulse, .realign_pulse, .phase_offset, .wideband,
    .modulator_restart
  );
  prt_serial_host prt_serial_host_i (.hclk, .sclk_pin, .sdata_pin, .load_strobe_pin);

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // realigns only counts pulses that land on a sync pulse
  always @(posedge hclk) begin
    syncs <= syncs + {31'h0, sync_pulse === 1'b1};
    realigns <= realigns + {31'h0, (realign_pulse === 1'b1) && (sync_pulse === 1'b1)};
    restarts <= restarts + {31'h0, modulator_restart === 1'b1};
    wb_cycles <= wb_cycles + {31'h0, wideband === 1'b1};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  function automatic logic [28:0] fld(input logic [11:0] v, input logic [2:0] a);
    return {14'h0, v, a};
  endfunction

  function automatic logic [28:0] mode_w(input logic [1:0] m, input logic [11:0] c);
    return {8'h0, m, c, 4'h0, prt_pkg::ADDR_MODE};
  endfunction

  function automatic logic [28:0] func_w(input logic sd, input logic dth);
    return {14'h0, sd, dth, 10'h0, prt_pkg::ADDR_FUNCTION};
  endfunction

  task automatic send(input logic [28:0] w);
    prt_serial_host_i.send_word(w);
    tick(1);
  endtask

  task automatic wait_sync(output logic [31:0] n);
    logic [31:0] s;
    s = syncs;
    n = 32'h0;
    while (syncs == s && n < 32'd2000) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_load;
    send(fld(PH, prt_pkg::ADDR_PHASE));
    send(fld(12'h005, prt_pkg::ADDR_MODULUS));
    // interval of 20 cycles, count inside 1..4095 and longer than settling
    send(mode_w(2'h2, 12'h004));
    ahb(1'b0, prt_pkg::OFS_PHASE_WORD, 32'h0);
    chk(rd, {3'h0, fld(PH, prt_pkg::ADDR_PHASE)});
    ahb(1'b0, prt_pkg::OFS_MODULUS_WORD, 32'h0);
    chk(rd, {3'h0, fld(12'h005, prt_pkg::ADDR_MODULUS)});
    ahb(1'b1, prt_pkg::OFS_CTRL, 32'h0);
    send(mode_w(2'h2, 12'h009));
    ahb(1'b0, prt_pkg::OFS_MODE_WORD, 32'h0);
    chk(rd, {3'h0, mode_w(2'h2, 12'h004)});
    ahb(1'b1, prt_pkg::OFS_CTRL, prt_pkg::CTRL_RST);
  endtask

  task automatic t_realign;
    logic [31:0] n;
    logic [31:0] r;
    logic [31:0] a;
    wait_sync(n);
    wait_sync(n);
    chk(n, 32'd20);
    // ten frozen edges stretch the wait for the next pulse from 9 to 19 edges
    wait_sync(n);
    @(posedge hclk);
    ce <= 1'b0;
    repeat (10) @(posedge hclk);
    ce <= 1'b1;
    wait_sync(n);
    chk(n, 32'd19);
    r = restarts;
    a = realigns;
    send(FREQ);
    chk(restarts - r, 32'h1);
    wait_sync(n);
    chk(realigns - a, 32'h0);
    wait_sync(n);
    chk(realigns - a, 32'h1);
    chk({20'h0, phase_offset}, {20'h0, PH});
    wait_sync(n);
    chk(realigns - a, 32'h1);
    ahb(1'b0, prt_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[prt_pkg::ST_REALIGNED]}, 32'h1);
    ahb(1'b1, prt_pkg::OFS_STATUS, 32'h1);
    ahb(1'b0, prt_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[prt_pkg::ST_REALIGNED]}, 32'h0);
    // latch falls 5 or 6 edges before send returns, so the first pulse is near 15
    send(fld(12'h005, prt_pkg::ADDR_MODULUS));
    wait_sync(n);
    chk({31'h0, n >= 32'd12 && n <= 32'd17}, 32'h1);
  endtask

  task automatic t_restart_off;
    logic [31:0] r;
    logic [31:0] n;
    send(func_w(1'b1, 1'b0));
    send(fld(PH2, prt_pkg::ADDR_PHASE));
    r = restarts;
    send(FREQ);
    chk(restarts - r, 32'h0);
    // no restart, so only the realign may bring the new phase word out
    chk({20'h0, phase_offset}, {20'h0, PH});
    wait_sync(n);
    wait_sync(n);
    chk({20'h0, phase_offset}, {20'h0, PH2});
    send(func_w(1'b0, 1'b0));
  endtask

  task automatic t_fastlock;
    logic [31:0] w;
    send(mode_w(2'h1, 12'h007));
    tick(30);
    w = wb_cycles;
    send(FREQ);
    tick(30);
    chk(wb_cycles - w, 32'd7);
  endtask

  task automatic t_moderr;
    logic [11:0] mods [4] = '{12'h002, 12'h032, 12'h031, 12'h001};
    logic        dth [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] s;
    send(mode_w(2'h2, 12'h004));
    for (int i = 0; i < 4; i++) begin
      send(func_w(1'b0, dth[i]));
      send(fld(mods[i], prt_pkg::ADDR_MODULUS));
      ahb(1'b0, prt_pkg::OFS_STATUS, 32'h0);
      chk({31'h0, rd[prt_pkg::ST_MODULUS_ERR]}, {31'h0, i >= 2});
    end
    s = syncs;
    tick(100);
    chk(syncs - s, 32'h0);
    send(fld(12'h005, prt_pkg::ADDR_MODULUS));
    send(mode_w(2'h0, 12'h004));
    s = syncs;
    tick(100);
    chk(syncs - s, 32'h0);
    send(mode_w(2'h2, 12'h000));
    s = syncs;
    tick(100);
    chk(syncs - s, 32'h0);
  endtask

  task automatic wrap_up;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // whole sequence needs about 70 us
  initial begin
    #300000;
    failures++;
    wrap_up();
  end

  initial begin
    tick(12);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    @(posedge hclk);
    hresetn <= 1'b1;
    tick(3);
    ahb(1'b0, prt_pkg::OFS_CTRL, 32'h0);
    chk(rd, prt_pkg::CTRL_RST);
    ahb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    t_load();
    t_realign();
    t_restart_off();
    t_fastlock();
    t_moderr();
    wrap_up();
  end
endmodule
